// ===== sbc_mode_fsm.v
// Operating-mode state machine with power-up straps and serial frame receiver
`timescale 1ns/1ps
`include "sbc_mode_map.vh"

// Operation
// - After power-on reset start in init mode with long open watchdog window.
// - Soft reset also brings the device into init mode.
// - Six modes: init, normal, stop, sleep, restart, fail-safe.
// - Stop mode keeps main regulator on.
// - Sleep mode switches main regulator off.
// - Wake from sleep/fail-safe or failure enters restart; reset held low.
// - Restart returns to normal after reset delay once failure cleared.
// - Critical failures enter fail-safe with main regulator off.
// - Fail-safe left on wake, on soft reset, or on overtemperature gone with cfg_fail_to_failsafe low.
// - Debug mode halts watchdog counter; no triggers required.
// - Debug mode still allows all six modes.
// - Serial configuration uses 16-bit frames.
// - Mode field cleared when passing through restart.
// - Watchdog and overvoltage reaction latched from interrupt pin at power-up.
// - Debug or normal operation chosen from strap pin level at power-up.
// - In init any serial frame, even illegal, moves to normal.
// - Missing trigger in long open window flags watchdog failure, enters restart, or fail-safe without pull-up.
// - Interrupt-pin configuration latched on reset output rising edge.
// - Wake events during init are discarded.
module sbc_mode_fsm #(
    parameter [31:0] LW_CYCLES = `SBC_LW_CYCLES,
    parameter [31:0] RD_CYCLES = `SBC_RD_CYCLES
) (
    // Clock and power-on reset
    input wire clk_sys,
    input wire reset,
    // Serial interface pins
    input wire spi_sck,
    input wire spi_csn,
    input wire spi_sdi,
    // Events
    input wire soft_reset,
    input wire wd_trigger,
    input wire wake_can,
    input wire wake_lin,
    input wire [2:0] wake_inputs,
    input wire main_reg_undervoltage,
    input wire main_reg_overvoltage,
    input wire overtemp,
    input wire cfg_fail_to_failsafe,
    // Strap pins
    input wire int_pin_level,
    input wire fail_output3_debug_strap_pin,
    // Status
    output reg [2:0] mode_q,
    output reg [1:0] mode_field_q,
    output reg main_regulator_enable_q,
    output reg reset_output_pin_q,
    output reg wd_fail_q,
    output reg wake_seen_q,
    output reg debug_mode_q,
    output reg cfg_pullup_q,
    output reg [15:0] last_frame_q
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [10:0] pins_s;
    sbc_sync2 #(.W(11)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .d({spi_sck, ~spi_csn, spi_sdi, wake_can, wake_lin, wake_inputs,
            int_pin_level, fail_output3_debug_strap_pin, overtemp}),
        .q(pins_s)
    );
    wire sck_s = pins_s[10];
    // Chip select enters inverted so its reset value equals idle, no false frame end
    wire csn_s = ~pins_s[9];
    wire sdi_s = pins_s[8];
    wire wake_any = |pins_s[7:3];
    wire int_s = pins_s[2];
    wire strap_s = pins_s[1];
    wire overtemp_s = pins_s[0];

    // ----------------------------------------------------------------
    // 16-bit serial frame receiver
    // ----------------------------------------------------------------
    reg sck_prev_q;
    reg csn_prev_q;
    reg [15:0] shift_q;
    reg [4:0] bitcnt_q;
    reg frame_q;
    reg frame_ok_q;
    wire sck_rise = sck_s & ~sck_prev_q;
    wire frame_end = csn_s & ~csn_prev_q;

    always @(posedge clk_sys) begin
        if (reset) begin
            sck_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
            shift_q <= 16'h0000;
            bitcnt_q <= 5'h00;
            frame_q <= 1'b0;
            frame_ok_q <= 1'b0;
            last_frame_q <= 16'h0000;
        end else begin
            sck_prev_q <= sck_s;
            csn_prev_q <= csn_s;
            frame_q <= 1'b0;
            if (csn_s) begin
                bitcnt_q <= 5'h00;
            end else if (sck_rise) begin
                shift_q <= {shift_q[14:0], sdi_s};
                // Saturates above 16 so long frames stay illegal
                if (bitcnt_q != 5'h1F) begin
                    bitcnt_q <= bitcnt_q + 5'h01;
                end
            end
            if (frame_end) begin
                frame_q <= 1'b1; // any frame, legal or not
                // Length kept here, the bit counter clears on this edge
                frame_ok_q <= (bitcnt_q == `SBC_FRAME_BITS);
                last_frame_q <= shift_q;
            end
        end
    end

    wire frame_legal = frame_ok_q;
    wire [1:0] req_mode = shift_q[`SBC_FRAME_MODE_MSB:`SBC_FRAME_MODE_LSB];

    // ----------------------------------------------------------------
    // Watchdog and delay counters
    // ----------------------------------------------------------------
    reg [31:0] wd_cnt_q;
    reg [31:0] rd_cnt_q;
    reg reset_out_prev_q;
    wire wd_expired = (wd_cnt_q >= LW_CYCLES - 32'h1);
    wire rd_done = (rd_cnt_q >= RD_CYCLES - 32'h1);
    wire wd_failure = wd_expired & ~debug_mode_q & (mode_q == `SBC_MODE_INIT);
    wire failure = wd_failure | main_reg_undervoltage | main_reg_overvoltage;
    // Watchdog and overvoltage route follows the latched strap, no pull-up means fail-safe
    wire go_failsafe = ((wd_failure | main_reg_overvoltage) & ~cfg_pullup_q) |
                       (main_reg_undervoltage & cfg_fail_to_failsafe);

    // ----------------------------------------------------------------
    // Mode state machine
    // ----------------------------------------------------------------
    reg [2:0] mode_d;
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            `SBC_MODE_INIT: begin
                if (failure) begin
                    mode_d = go_failsafe ? `SBC_MODE_FAILSAFE : `SBC_MODE_RESTART;
                end else if (frame_q) begin
                    mode_d = `SBC_MODE_NORMAL;
                end
            end
            `SBC_MODE_NORMAL, `SBC_MODE_STOP: begin
                if (failure) begin
                    mode_d = go_failsafe ? `SBC_MODE_FAILSAFE : `SBC_MODE_RESTART;
                end else if (frame_q && frame_legal) begin
                    case (req_mode)
                        `SBC_REQ_NORMAL: mode_d = `SBC_MODE_NORMAL;
                        `SBC_REQ_SLEEP: mode_d = `SBC_MODE_SLEEP;
                        `SBC_REQ_STOP: mode_d = `SBC_MODE_STOP;
                        `SBC_REQ_RESET: mode_d = `SBC_MODE_RESTART;
                        default: mode_d = mode_q;
                    endcase
                end
            end
            `SBC_MODE_SLEEP: begin
                if (wake_any) begin
                    mode_d = `SBC_MODE_RESTART;
                end
            end
            `SBC_MODE_RESTART: begin
                if (rd_done && !failure) begin
                    mode_d = `SBC_MODE_NORMAL;
                end
            end
            `SBC_MODE_FAILSAFE: begin
                if (wake_any || (cfg_fail_to_failsafe == 1'b0 && !overtemp_s)) begin
                    mode_d = `SBC_MODE_RESTART;
                end
            end
            default: mode_d = `SBC_MODE_INIT;
        endcase
        if (soft_reset) begin
            mode_d = `SBC_MODE_INIT;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            mode_q <= `SBC_MODE_INIT;
            mode_field_q <= `SBC_REQ_NORMAL;
            main_regulator_enable_q <= 1'b1;
            reset_output_pin_q <= 1'b0;
            reset_out_prev_q <= 1'b0;
            wd_cnt_q <= 32'h0;
            rd_cnt_q <= 32'h0;
            wd_fail_q <= 1'b0;
            wake_seen_q <= 1'b0;
            debug_mode_q <= 1'b0;
            cfg_pullup_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            // Regulator on except sleep and fail-safe
            main_regulator_enable_q <= (mode_d != `SBC_MODE_SLEEP) &&
                                       (mode_d != `SBC_MODE_FAILSAFE);
            // Reset low in restart, in fail-safe and during init delay
            reset_output_pin_q <= (mode_d != `SBC_MODE_RESTART) &&
                                  (mode_d != `SBC_MODE_FAILSAFE) &&
                                  !(mode_q == `SBC_MODE_INIT && !reset_output_pin_q && !rd_done);
            reset_out_prev_q <= reset_output_pin_q;
            if (mode_d == `SBC_MODE_RESTART) begin
                mode_field_q <= `SBC_REQ_NORMAL;
            end else if (frame_q && frame_legal && mode_q != `SBC_MODE_INIT) begin
                mode_field_q <= req_mode;
            end
            if (mode_q != mode_d || reset_output_pin_q) begin
                rd_cnt_q <= 32'h0;
            end else if (!rd_done) begin
                rd_cnt_q <= rd_cnt_q + 32'h1;
            end
            // Long open window runs in init unless debug halts it
            if (mode_q != `SBC_MODE_INIT || wd_trigger) begin
                wd_cnt_q <= 32'h0;
            end else if (!debug_mode_q && !wd_expired) begin
                wd_cnt_q <= wd_cnt_q + 32'h1;
            end
            if (wd_failure) begin
                wd_fail_q <= 1'b1;
            end
            if (wake_any && mode_q != `SBC_MODE_INIT) begin
                wake_seen_q <= 1'b1;
            end else if (frame_q) begin
                wake_seen_q <= 1'b0; // init wakes dropped
            end
            if (mode_q == `SBC_MODE_INIT && !reset_output_pin_q) begin
                debug_mode_q <= ~strap_s;
            end
            if (reset_output_pin_q && !reset_out_prev_q && mode_q == `SBC_MODE_INIT) begin
                cfg_pullup_q <= int_s;
            end
        end
    end
endmodule // sbc_mode_fsm

// ===== sbc_mode_map.vh
// Mode encodings, mode-field codes and timing counts of the operating-mode machine
`ifndef SBC_MODE_MAP_VH
`define SBC_MODE_MAP_VH

// ----------------------------------------------------------------
// Operating modes (state register codes)
// ----------------------------------------------------------------
`define SBC_MODE_INIT 3'h0
`define SBC_MODE_NORMAL 3'h1
`define SBC_MODE_STOP 3'h2
`define SBC_MODE_SLEEP 3'h3
`define SBC_MODE_RESTART 3'h4
`define SBC_MODE_FAILSAFE 3'h5

// ----------------------------------------------------------------
// Mode field of the mode-select control frame
// ----------------------------------------------------------------
`define SBC_FRAME_MODE_MSB 15
`define SBC_FRAME_MODE_LSB 14
`define SBC_REQ_NORMAL 2'h0
`define SBC_REQ_SLEEP 2'h1
`define SBC_REQ_STOP 2'h2
`define SBC_REQ_RESET 2'h3
`define SBC_FRAME_BITS 5'h10

// ----------------------------------------------------------------
// Timing: 40 MHz clock, 25 ns period
// ----------------------------------------------------------------
`define SBC_CLK_PERIOD_NS 25
`define SBC_LONG_OPEN_WINDOW_TIME_MS 200
`define SBC_RESET_DELAY_TIME_MS 10
`define SBC_LW_CYCLES (`SBC_LONG_OPEN_WINDOW_TIME_MS * 1000000 / `SBC_CLK_PERIOD_NS)
`define SBC_RD_CYCLES (`SBC_RESET_DELAY_TIME_MS * 1000000 / `SBC_CLK_PERIOD_NS)

`endif

// ===== sbc_sync2.v
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sbc_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sbc_sync2

// ===== sbc_mode_fsm_monitor.sv
// Port checker of the operating-mode machine
`timescale 1ns/1ps
`include "sbc_mode_map.vh"
module sbc_mode_fsm_monitor (
    // Clock, reset, events
    input wire clk_sys,
    input wire reset,
    input wire soft_reset,
    // Status
    input wire [2:0] mode_q,
    input wire [1:0] mode_field_q,
    input wire main_regulator_enable_q,
    input wire reset_output_pin_q,
    input wire wd_fail_q,
    input wire debug_mode_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    sequence s_enter_restart;
        mode_q != `SBC_MODE_RESTART ##1 mode_q == `SBC_MODE_RESTART;
    endsequence
    sequence s_leave_restart;
        mode_q == `SBC_MODE_RESTART ##1 mode_q != `SBC_MODE_RESTART;
    endsequence
    a_mode_code_legal: assert property (mode_q <= `SBC_MODE_FAILSAFE)
        else $error("mode code out of range");
    a_stop_reg_on: assert property (mode_q == `SBC_MODE_STOP |-> main_regulator_enable_q)
        else $error("regulator off in stop");
    a_sleep_reg_off: assert property (mode_q == `SBC_MODE_SLEEP |-> !main_regulator_enable_q)
        else $error("regulator on in sleep");
    a_failsafe_reg_off: assert property (mode_q == `SBC_MODE_FAILSAFE |-> !main_regulator_enable_q)
        else $error("regulator on in fail-safe");
    a_restart_holds_rst: assert property (mode_q == `SBC_MODE_RESTART |-> !reset_output_pin_q)
        else $error("reset released in restart");
    a_restart_clears_field: assert property (s_enter_restart |-> ##1 mode_field_q == 2'h0)
        else $error("mode field kept in restart");
    a_restart_exit_normal: assert property (s_leave_restart |-> mode_q == `SBC_MODE_NORMAL || $past(soft_reset))
        else $error("restart left to wrong mode");
    a_soft_reset_init: assert property (soft_reset |=> mode_q == `SBC_MODE_INIT)
        else $error("soft reset missed init");
    a_power_up_init: assert property ($fell(reset) |-> mode_q == `SBC_MODE_INIT && !reset_output_pin_q)
        else $error("no init after power-up");
    a_wd_fail_restart: assert property ($rose(wd_fail_q) |-> ##[0:2] (mode_q == `SBC_MODE_RESTART || mode_q == `SBC_MODE_FAILSAFE))
        else $error("watchdog failure without mode change");
    a_debug_no_wd_fail: assert property (debug_mode_q |-> !$rose(wd_fail_q))
        else $error("watchdog failed in debug mode");
endmodule // sbc_mode_fsm_monitor
bind sbc_mode_fsm sbc_mode_fsm_monitor u_mon (.clk_sys(clk_sys), .reset(reset),
    .soft_reset(soft_reset), .mode_q(mode_q), .mode_field_q(mode_field_q),
    .main_regulator_enable_q(main_regulator_enable_q), .reset_output_pin_q(reset_output_pin_q),
    .wd_fail_q(wd_fail_q), .debug_mode_q(debug_mode_q));

// ===== sbc_host_model.sv
// Host model driving the serial frame pins
`timescale 1ns/1ps
module sbc_host_model (
    // Clock
    input wire clk_sys,
    // Serial pins
    output reg spi_sck,
    output reg spi_csn,
    output reg spi_sdi
);
    initial begin
        spi_sck = 1'h0;
        spi_csn = 1'h1;
        spi_sdi = 1'h0;
    end
    // MSB first, four clocks per clock phase
    task send_frame(input [15:0] f);
        integer i;
        begin
            spi_csn = 1'h0;
            for (i = 15; i >= 0; i = i - 1) begin
                spi_sdi = f[i];
                repeat (4) @(posedge clk_sys);
                #2;
                spi_sck = 1'h1;
                repeat (4) @(posedge clk_sys);
                #2;
                spi_sck = 1'h0;
            end
            repeat (4) @(posedge clk_sys);
            #2;
            spi_csn = 1'h1;
            spi_sdi = ~spi_sdi;
        end
    endtask
endmodule // sbc_host_model

// ===== tb_sbc_mode_fsm.sv
// Testbench of the operating-mode machine
`timescale 1ns/1ps
`include "sbc_mode_map.vh"
module tb_sbc_mode_fsm;
    reg clk_sys = 1'h0;
    reg reset = 1'h1;
    reg soft_reset = 1'h0;
    reg wake_can = 1'h0;
    reg wake_lin = 1'h0;
    reg cfg_fs = 1'h1;
    reg int_lvl = 1'h1;
    reg strap = 1'h1;
    reg wd_trig = 1'h0;
    reg uv = 1'h0;
    wire sck, csn, sdi, reg_en, rst_pin, wd_fail, wake_seen, dbg, cfg_pu;
    wire [15:0] last_frame;
    wire [2:0] mode_q;
    wire [1:0] field;
    integer err_total = 0;
    integer cmp_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    sbc_host_model u_host (.clk_sys(clk_sys), .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi));
    sbc_mode_fsm #(.LW_CYCLES(400), .RD_CYCLES(20)) u_dut (.clk_sys(clk_sys), .reset(reset),
        .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi), .soft_reset(soft_reset),
        .wd_trigger(wd_trig), .wake_can(wake_can), .wake_lin(wake_lin), .wake_inputs(3'h0),
        .main_reg_undervoltage(uv), .main_reg_overvoltage(1'h0), .overtemp(1'h0),
        .cfg_fail_to_failsafe(cfg_fs), .int_pin_level(int_lvl),
        .fail_output3_debug_strap_pin(strap), .mode_q(mode_q), .mode_field_q(field),
        .main_regulator_enable_q(reg_en), .reset_output_pin_q(rst_pin), .wd_fail_q(wd_fail),
        .wake_seen_q(wake_seen), .debug_mode_q(dbg), .cfg_pullup_q(cfg_pu),
        .last_frame_q(last_frame));
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #2;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_mode(input [2:0] m, input integer lim);
        integer k;
        begin
            k = 0;
            while (mode_q !== m && k < lim) begin
                cyc(1);
                k = k + 1;
            end
            chk(mode_q, m);
        end
    endtask
    task do_reset;
        begin
            reset = 1'h1;
            cyc(3);
            reset = 1'h0;
            cyc(3);
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        cyc(1);
        do_reset;
        chk(mode_q, `SBC_MODE_INIT);
        chk(rst_pin, 1'h0);
        cyc(25);
        chk(rst_pin, 1'h1);
        chk(cfg_pu, 1'h1);
        u_host.send_frame({`SBC_REQ_STOP, 14'h3FFF});
        wait_mode(`SBC_MODE_NORMAL, 40);
        chk(last_frame, {`SBC_REQ_STOP, 14'h3FFF});
        u_host.send_frame({`SBC_REQ_STOP, 14'h0});
        wait_mode(`SBC_MODE_STOP, 40);
        chk(field, `SBC_REQ_STOP);
        chk(reg_en, 1'h1);
        u_host.send_frame({`SBC_REQ_SLEEP, 14'h0});
        wait_mode(`SBC_MODE_SLEEP, 40);
        chk(reg_en, 1'h0);
        wake_can = 1'h1;
        cyc(5);
        wake_can = 1'h0;
        wait_mode(`SBC_MODE_RESTART, 20);
        chk(rst_pin, 1'h0);
        chk(field, 2'h0);
        chk(wake_seen, 1'h1);
        wait_mode(`SBC_MODE_NORMAL, 60);
        $display("test mode walk done");
        soft_reset = 1'h1;
        cyc(1);
        soft_reset = 1'h0;
        wait_mode(`SBC_MODE_INIT, 4);
        // Trigger inside the window restarts it
        cyc(300);
        wd_trig = 1'h1;
        cyc(1);
        wd_trig = 1'h0;
        cyc(300);
        chk(mode_q, `SBC_MODE_INIT);
        // Pull-up strap latched high: watchdog failure goes to restart
        wait_mode(`SBC_MODE_RESTART, 200);
        chk(wd_fail, 1'h1);
        wait_mode(`SBC_MODE_NORMAL, 60);
        uv = 1'h1;
        cyc(1);
        uv = 1'h0;
        wait_mode(`SBC_MODE_FAILSAFE, 4);
        chk(reg_en, 1'h0);
        wake_lin = 1'h1;
        cyc(5);
        wake_lin = 1'h0;
        wait_mode(`SBC_MODE_RESTART, 20);
        wait_mode(`SBC_MODE_NORMAL, 60);
        $display("test failure path done");
        strap = 1'h0;
        int_lvl = 1'h0;
        do_reset;
        wake_can = 1'h1;
        cyc(5);
        wake_can = 1'h0;
        chk(wake_seen, 1'h0);
        cyc(500);
        chk(mode_q, `SBC_MODE_INIT);
        chk(wd_fail, 1'h0);
        chk(dbg, 1'h1);
        chk(cfg_pu, 1'h0);
        u_host.send_frame({`SBC_REQ_NORMAL, 14'h0});
        wait_mode(`SBC_MODE_NORMAL, 40);
        u_host.send_frame({`SBC_REQ_STOP, 14'h0});
        wait_mode(`SBC_MODE_STOP, 40);
        cfg_fs = 1'h0;
        uv = 1'h1;
        cyc(1);
        uv = 1'h0;
        wait_mode(`SBC_MODE_RESTART, 4);
        chk(field, 2'h0);
        wait_mode(`SBC_MODE_NORMAL, 60);
        $display("test debug start done");
        tally_and_finish;
    end
    initial begin
        #(25 * 10000);
        err_total = err_total + 1;
        $display("ERROR %0t run did not finish", $time);
        tally_and_finish;
    end
endmodule // tb_sbc_mode_fsm
